//--- dv/gpm_mem_model.sv
/* external memory seen on the port f data pins.
   assumes the bench says when a read cycle has the memory driving. */
module gpm_mem_model (
   input  logic       clk,
   input  logic       rd_en,
   input  logic [3:0] rd_data,
   input  logic [3:0] pf_out,
   input  logic [3:0] pf_oe,
   input  logic [3:0] pf_pu,
   output logic [3:0] pf_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] last_q = 4'h0;
   // a floating pin shows 1 under its pull-up, else the inverse of its last level, never a guess
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pf_in[i] = pf_oe[i] ? pf_out[i] : rd_en ? rd_data[i]
                  : pf_pu[i] ? 1'b1 : ~last_q[i];
      end
   end
   always @(posedge clk) begin
      last_q <= pf_in;
   end
endmodule // gpm_mem_model

//--- dv/gpm_pin_mux_monitor.sv
/* port checker for the shared pin multiplexer.
   assumes one clock domain and the active-low asynchronous reset. */
module gpm_pin_mux_monitor (
   input logic        CLOCK,
   input logic        RST_B,
   input logic [7:0]  REG_ADDR,
   input logic        REG_RD,
   input logic [15:0] REG_RDATA,
   input logic [5:0]  EMI_ADDR_MID,
   input logic        EMI_DATA_OE,
   input logic        EMI_BUS_ACTIVE,
   input logic [3:0]  EMI_DIN,
   input logic        BUS_DRIVE_KEEP,
   input logic [5:0]  PA_OUT,
   input logic [5:0]  PA_OE,
   input logic [4:0]  PB_OE,
   input logic [3:0]  PF_OE,
   input logic [3:0]  PF_IN,
   input logic [5:0]  PA_PU,
   input logic [4:0]  PB_PU,
   input logic [3:0]  PF_PU
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // pads must stay off during reset, so this one is never disabled
   oe_in_reset_a: assert property (@(posedge CLOCK) disable iff (1'b0)
      !RST_B |-> {PA_OE, PB_OE, PF_OE} == 15'h0) else $error("pad on in reset");
   rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0)
      else $error("read data outside read slot");
   rdata_upper_a: assert property (REG_RD |=> REG_RDATA[15:6] == 10'h0)
      else $error("upper read bits set");
   pu_reset_a: assert property ($rose(RST_B) |->
      {PA_PU, PB_PU, PF_PU} == 15'h7fff) else $error("pull-up off at reset");
   b_gpio_reset_a: assert property ($rose(RST_B) |-> PB_OE == 5'h0)
      else $error("port b driving after reset");
   a_bus_reset_a: assert property ($rose(RST_B) |->
      PA_OE == {6{EMI_BUS_ACTIVE}} && PA_OUT == EMI_ADDR_MID)
      else $error("port a not in address function");
   f_bus_reset_a: assert property ($rose(RST_B) |->
      PF_OE == {4{EMI_DATA_OE & EMI_BUS_ACTIVE}}) else $error("port f not bus");
   din_mask_a: assert property ((EMI_DIN & ~$past(PF_IN)) == 4'h0)
      else $error("bus data not from pads");
   keep_rd_a: assert property (REG_RD && REG_ADDR == 8'h19 |=>
      REG_RDATA == {15'h0, $past(BUS_DRIVE_KEEP)}) else $error("keep readback");
   cover property (BUS_DRIVE_KEEP && !EMI_BUS_ACTIVE && PA_OE == 6'h3f);
   cover property (EMI_BUS_ACTIVE && PF_OE == 4'hf);
   cover property (PB_OE[4] && !EMI_BUS_ACTIVE);
endmodule // gpm_pin_mux_monitor

//--- dv/gpm_pin_mux_test.sv
/* self-checking bench for the shared pin multiplexer.
   assumes the memory model on port f and bench-driven a/b pads. */
module gpm_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, keep;
   logic        data_oe = 0, bus_act = 0, pre_clk = 0, mem_rd = 0;
   logic [7:0]  reg_addr = 0;
   logic [15:0] reg_wdata = 0, reg_rdata;
   logic [5:0]  addr_mid = 0, pa_in = 6'h2a, pa_out, pa_oe, pa_pu;
   logic [4:0]  addr_hi = 0, pb_in = 0, pb_out, pb_oe, pb_pu;
   logic [3:0]  dout = 0, din, mem_data = 0, pf_in, pf_out, pf_oe, pf_pu;
   int          bad_count = 0, comparisons = 0;
   gpm_pin_mux u_gpm_pin_mux (.CLOCK(clock), .RST_B(rst_b),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .EMI_ADDR_MID(addr_mid),
      .EMI_ADDR_HI(addr_hi), .EMI_DOUT(dout), .EMI_DATA_OE(data_oe),
      .EMI_BUS_ACTIVE(bus_act), .EMI_DIN(din), .BUS_DRIVE_KEEP(keep),
      .PRESCALER_CLK(pre_clk), .PA_IN(pa_in), .PA_OUT(pa_out),
      .PA_OE(pa_oe), .PA_PU(pa_pu), .PB_IN(pb_in), .PB_OUT(pb_out),
      .PB_OE(pb_oe), .PB_PU(pb_pu), .PF_IN(pf_in), .PF_OUT(pf_out),
      .PF_OE(pf_oe), .PF_PU(pf_pu));
   gpm_mem_model u_gpm_mem_model (.clk(clock), .rd_en(mem_rd),
      .rd_data(mem_data), .pf_out(pf_out), .pf_oe(pf_oe), .pf_pu(pf_pu),
      .pf_in(pf_in));
   // 100 MHz clock
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic give_verdict;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // one gap cycle after each strobe keeps a strobe from being set twice
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task automatic t_reset;
      logic [7:0]  a [10] = '{8'h02, 8'h0a, 8'h12, 8'h03, 8'h0b, 8'h13,
                              8'h01, 8'h18, 8'h19, 8'h1f};
      logic [15:0] e [10] = '{16'h3f, 16'h0, 16'hf, 16'h3f, 16'h1f, 16'hf,
                              16'h0, 16'h0, 16'h0, 16'h0};
      for (int i = 0; i < 10; i++) begin
         rd(a[i], e[i]);
      end
   endtask
   task automatic t_addr;
      @(posedge clock);
      addr_mid <= 6'h25;
      addr_hi <= 5'h0a;
      bus_act <= 1'b1;
      wr(8'h0a, 16'h1f);
      chk(16'({pa_oe, pa_out}), 16'hfe5);
      chk(16'({pb_oe, pb_out}), 16'h3ea);
      @(posedge clock);
      bus_act <= 1'b0;
      wr(8'h19, 16'h1);
      chk(16'({keep, pa_oe, pb_oe}), 16'hfff);
      rd(8'h19, 16'h1);
      wr(8'h19, 16'h0);
      chk(16'({pa_oe, pb_oe}), 16'h0);
   endtask
   task automatic t_data;
      @(posedge clock);
      bus_act <= 1'b1;
      data_oe <= 1'b1;
      dout <= 4'h9;
      #1;
      chk(16'({pf_oe, pf_out}), 16'hf9);
      @(posedge clock);
      bus_act <= 1'b0;
      #1;
      chk(16'(pf_oe), 16'h0);
      @(posedge clock);
      bus_act <= 1'b1;
      data_oe <= 1'b0;
      mem_rd <= 1'b1;
      mem_data <= 4'h6;
      repeat (2) @(posedge clock);
      #1;
      chk(16'({pf_oe, din}), 16'h06);
      mem_rd <= 1'b0;
   endtask
   task automatic t_gpio;
      wr(8'h12, 16'h0);
      wr(8'h11, 16'h5);
      wr(8'h10, 16'hf);
      wr(8'h02, 16'h0);
      @(posedge clock);
      data_oe <= 1'b1;
      #1;
      chk(16'({pa_oe, pf_oe, pf_out}), 16'h05f);
      wr(8'h0a, 16'h0);
      wr(8'h09, 16'h15);
      wr(8'h08, 16'h0a);
      pb_in <= 5'h13;
      chk(16'({pb_oe, pb_out}), 16'h2aa);
      rd(8'h0c, 16'h13);
      rd(8'h04, 16'h2a);
      wr(8'h0b, 16'h0f);
      chk(16'(pb_pu), 16'h0f);
      wr(8'h03, 16'h2e);
      wr(8'h13, 16'h6);
      chk(16'({pa_pu, pf_pu}), 16'h2e6);
   endtask
   task automatic t_clk;
      wr(8'h0a, 16'h10);
      wr(8'h18, 16'h1);
      bus_act <= 1'b0;
      for (int v = 0; v < 2; v++) begin
         @(posedge clock);
         pre_clk <= v[0];
         #1;
         chk(16'({pb_oe[4], pb_out[4]}), 16'(v + 2));
      end
      wr(8'h18, 16'h0);
      addr_hi <= 5'h10;
      bus_act <= 1'b1;
      pre_clk <= 1'b0;
      #1;
      chk(16'(pb_out[4]), 16'h1);
   endtask
   task automatic t_rst;
      wr(8'h09, 16'h1f);
      rst_b <= 1'b0;
      #1;
      chk(16'({pa_oe, pb_oe, pf_oe}), 16'h0);
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h0a, 16'h0);
      chk(16'({pb_oe, pb_pu}), 16'h1f);
      chk(16'({pa_pu, pf_pu}), 16'h3ff);
   endtask
   // a hang is cut short well past the fewer than 100 cycles of the tests
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_addr();
      t_data();
      t_gpio();
      t_clk();
      t_rst();
      give_verdict();
   end
endmodule // gpm_pin_mux_test
bind gpm_pin_mux gpm_pin_mux_monitor u_gpm_pin_mux_monitor (.*);

//--- rtl/gpm_gpio_port.v
/*
 * one GPIO port: data, direction, peripheral enable and pull-up
 * registers, plus a sampled copy of the pad levels.
 * assumes the register strobes of the top module and pads synchronous
 * to clk.
 */
`include "gpm_map.vh"

module gpm_gpio_port #(
   parameter         W       = 6,
   parameter [7:0]   BASE    = 8'h00,
   parameter [W-1:0] PER_RST = {W{1'b0}}
) (
   input  wire          clk,
   input  wire          rst_b,
   input  wire          wr_en,
   input  wire [7:0]    addr,
   input  wire [15:0]   wdata,
   input  wire [W-1:0]  pin_in,
   output reg  [W-1:0]  data_q,
   output reg  [W-1:0]  dir_q,
   output reg  [W-1:0]  per_q,
   output reg  [W-1:0]  pur_q,
   output reg  [W-1:0]  pin_q,
   output wire          hit,
   output reg  [15:0]   rd_val
);

   // address match for one register of this block
   function reg_hit;
      input [7:0] a;
      input [2:0] r;
      begin
         reg_hit = (a == (BASE | {5'h00, r}));
      end
   endfunction

   assign hit = (addr[7:3] == BASE[7:3]) && (addr[2:0] <= `GPM_REG_PIN);

   // register writes; reset clears every direction bit to input, sets every pull-up and loads per_q with PER_RST
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= {W{1'b0}};
         dir_q  <= {W{1'b0}};
         per_q  <= PER_RST;
         pur_q  <= {W{1'b1}};
         pin_q  <= {W{1'b0}};
      end else begin
         pin_q <= pin_in;
         if (wr_en && reg_hit(addr, `GPM_REG_DATA)) begin
            data_q <= wdata[W-1:0];
         end
         if (wr_en && reg_hit(addr, `GPM_REG_DIR)) begin
            dir_q <= wdata[W-1:0];
         end
         if (wr_en && reg_hit(addr, `GPM_REG_PER)) begin
            per_q <= wdata[W-1:0];
         end
         if (wr_en && reg_hit(addr, `GPM_REG_PUR)) begin
            pur_q <= wdata[W-1:0];
         end
      end
   end

   // read view; upper bits read as zero
   always @* begin
      rd_val = 16'h0000;
      case (addr[2:0])
         `GPM_REG_DATA: rd_val = {{(16-W){1'b0}}, data_q};
         `GPM_REG_DIR:  rd_val = {{(16-W){1'b0}}, dir_q};
         `GPM_REG_PER:  rd_val = {{(16-W){1'b0}}, per_q};
         `GPM_REG_PUR:  rd_val = {{(16-W){1'b0}}, pur_q};
         `GPM_REG_PIN:  rd_val = {{(16-W){1'b0}}, pin_q};
         default:       rd_val = 16'h0000;
      endcase
   end

endmodule // gpm_gpio_port

//--- rtl/gpm_map.vh
/*
 * constants for the shared pin multiplexer: register offsets, field
 * positions, widths and reset values.
 * assumes an 8-bit register address and 16-bit register data.
 */
// Summary of operation
// - each shared port B pin is individually a GPIO input or output
// - pull-up on pin n stays on until software clears bit n
// - port B pins leave reset in GPIO function, not address function
// - address pins carry bus address; tri-state when idle unless keep
// - port B pin 4 may output prescaler clock after GPIO disabled
// - data pins are bidirectional bus data; tri-state when bus idle unless keep
// - port F pins leave reset in data bus function
// - port A pins leave reset in address bus function
`ifndef GPM_MAP_VH
`define GPM_MAP_VH

`define GPM_AW              8
`define GPM_DW              16

// port widths
`define GPM_PA_W            6
`define GPM_PB_W            5
`define GPM_PF_W            4

// port register blocks
`define GPM_PORTA_BASE      8'h00
`define GPM_PORTB_BASE      8'h08
`define GPM_PORTF_BASE      8'h10

// register index inside a port block
`define GPM_REG_DATA        3'h0
`define GPM_REG_DIR         3'h1
`define GPM_REG_PER         3'h2
`define GPM_REG_PUR         3'h3
`define GPM_REG_PIN         3'h4

// single registers
`define GPM_CLOCK_OUT_SELECT_ADDR     8'h18
`define GPM_BUSCTL_ADDR     8'h19

// field positions
`define GPM_CLKO_SEL_BIT    0
`define GPM_DRV_KEEP_BIT    0
`define GPM_PB_CLK_PIN      4

// reset values
`define GPM_PA_PER_RST      6'h3f
`define GPM_PB_PER_RST      5'h00
`define GPM_PF_PER_RST      4'hf
`define GPM_CLOCK_OUT_SELECT_RST      1'b0
`define GPM_BUSCTL_RST      1'b0

`endif

//--- rtl/gpm_pad_mux.v
/*
 * per-pin choice between the GPIO function and the alternate function.
 * assumes rst_b is the raw active-low reset, used to force the pads
 * off while reset is held.
 */
module gpm_pad_mux #(
   parameter W = 6
) (
   input  wire          rst_b,
   input  wire [W-1:0]  per_en,
   input  wire [W-1:0]  gpio_out,
   input  wire [W-1:0]  gpio_dir,
   input  wire [W-1:0]  alt_out,
   input  wire [W-1:0]  alt_oe,
   output wire [W-1:0]  pad_out,
   output wire [W-1:0]  pad_oe
);

   // per set: alternate function owns the pin, else GPIO does
   assign pad_out = (per_en & alt_out) | (~per_en & gpio_out);

   // reset gates the enables combinationally so no pad drives in reset
   assign pad_oe = {W{rst_b}} &
                   ((per_en & alt_oe) | (~per_en & gpio_dir));

endmodule // gpm_pad_mux

//--- rtl/gpm_pin_mux.v
/*
 * shared pin multiplexer: ports A, B and F between GPIO and the
 * external memory bus, with the prescaler clock option on port B pin 4
 * and the bus drive keep bit.
 * assumes the bus controller supplies address, write data, a data
 * output request and a bus cycle active level, all synchronous to
 * CLOCK; the pad ring resolves each pin from its output and enable.
 * assumes software keeps ports A and F in GPIO function, since their
 * bus function has no pins here; the hardware does not enforce it.
 */
// The placing of the registers and the strobed register port were decided locally.
`include "gpm_map.vh"

module gpm_pin_mux (
   input  wire                   CLOCK,
   input  wire                   RST_B,
   // register port
   input  wire [`GPM_AW-1:0]     REG_ADDR,
   input  wire [`GPM_DW-1:0]     REG_WDATA,
   input  wire                   REG_WR,
   input  wire                   REG_RD,
   output wire [`GPM_DW-1:0]     REG_RDATA,
   // external memory interface side
   input  wire [5:0]             EMI_ADDR_MID,
   input  wire [4:0]             EMI_ADDR_HI,
   input  wire [3:0]             EMI_DOUT,
   input  wire                   EMI_DATA_OE,
   input  wire                   EMI_BUS_ACTIVE,
   output wire [3:0]             EMI_DIN,
   output wire                   BUS_DRIVE_KEEP,
   // prescaler clock for monitoring
   input  wire                   PRESCALER_CLK,
   // port A pads, shared with A8..A13
   input  wire [`GPM_PA_W-1:0]   PA_IN,
   output wire [`GPM_PA_W-1:0]   PA_OUT,
   output wire [`GPM_PA_W-1:0]   PA_OE,
   output wire [`GPM_PA_W-1:0]   PA_PU,
   // port B pads, shared with A16..A20 and the prescaler clock
   input  wire [`GPM_PB_W-1:0]   PB_IN,
   output wire [`GPM_PB_W-1:0]   PB_OUT,
   output wire [`GPM_PB_W-1:0]   PB_OE,
   output wire [`GPM_PB_W-1:0]   PB_PU,
   // port F pads, shared with D7..D10
   input  wire [`GPM_PF_W-1:0]   PF_IN,
   output wire [`GPM_PF_W-1:0]   PF_OUT,
   output wire [`GPM_PF_W-1:0]   PF_OE,
   output wire [`GPM_PF_W-1:0]   PF_PU
);

   // port register state
   wire [`GPM_PA_W-1:0]  pa_data;
   wire [`GPM_PA_W-1:0]  pa_dir;
   wire [`GPM_PA_W-1:0]  pa_per;
   wire [`GPM_PA_W-1:0]  pa_pur;
   wire                  pa_hit;
   wire [`GPM_DW-1:0]    pa_rd;
   wire [`GPM_PB_W-1:0]  pb_data;
   wire [`GPM_PB_W-1:0]  pb_dir;
   wire [`GPM_PB_W-1:0]  pb_per;
   wire [`GPM_PB_W-1:0]  pb_pur;
   wire                  pb_hit;
   wire [`GPM_DW-1:0]    pb_rd;
   wire [`GPM_PF_W-1:0]  pf_data;
   wire [`GPM_PF_W-1:0]  pf_dir;
   wire [`GPM_PF_W-1:0]  pf_per;
   wire [`GPM_PF_W-1:0]  pf_pur;
   wire                  pf_hit;
   wire [`GPM_DW-1:0]    pf_rd;

   // local control registers
   reg                   clko_sel_q;
   reg                   drv_keep_q;
   reg                   clko_sel_d;
   reg                   drv_keep_d;
   reg  [3:0]            emi_din_q;
   reg  [`GPM_DW-1:0]    rdata_q;
   reg  [`GPM_DW-1:0]    rdata_d;

   // alternate function drive
   wire                  addr_drive;
   wire                  data_drive;
   wire [`GPM_PB_W-1:0]  pb_alt_out;
   wire [`GPM_PB_W-1:0]  pb_alt_oe;
   wire                  clk_on_pin;
   wire [`GPM_PA_W-1:0]  pa_alt_oe;
   wire [`GPM_PF_W-1:0]  pf_alt_oe;

   // single register decode, shared by the write and the read path
   wire                  clko_hit;
   wire                  busctl_hit;
   wire                  clko_wr;
   wire                  busctl_wr;

   // bus read data from the data pins before the register
   wire [3:0]            emi_din_d;

   // exact address match for the stand-alone control registers
   function is_reg;
      input [`GPM_AW-1:0] a;
      input [`GPM_AW-1:0] r;
      begin
         is_reg = (a == r);
      end
   endfunction

   // port A: address bus after reset, software moves it to GPIO
   gpm_gpio_port #(
      .W       (`GPM_PA_W),
      .BASE    (`GPM_PORTA_BASE),
      .PER_RST (`GPM_PA_PER_RST)
   ) u_port_a (
      .clk     (CLOCK),
      .rst_b   (RST_B),
      .wr_en   (REG_WR),
      .addr    (REG_ADDR),
      .wdata   (REG_WDATA),
      .pin_in  (PA_IN),
      .data_q  (pa_data),
      .dir_q   (pa_dir),
      .per_q   (pa_per),
      .pur_q   (pa_pur),
      .pin_q   (),
      .hit     (pa_hit),
      .rd_val  (pa_rd)
   );

   // port B: GPIO after reset
   gpm_gpio_port #(
      .W       (`GPM_PB_W),
      .BASE    (`GPM_PORTB_BASE),
      .PER_RST (`GPM_PB_PER_RST)
   ) u_port_b (
      .clk     (CLOCK),
      .rst_b   (RST_B),
      .wr_en   (REG_WR),
      .addr    (REG_ADDR),
      .wdata   (REG_WDATA),
      .pin_in  (PB_IN),
      .data_q  (pb_data),
      .dir_q   (pb_dir),
      .per_q   (pb_per),
      .pur_q   (pb_pur),
      .pin_q   (),
      .hit     (pb_hit),
      .rd_val  (pb_rd)
   );

   // port F: data bus after reset, software moves it to GPIO
   gpm_gpio_port #(
      .W       (`GPM_PF_W),
      .BASE    (`GPM_PORTF_BASE),
      .PER_RST (`GPM_PF_PER_RST)
   ) u_port_f (
      .clk     (CLOCK),
      .rst_b   (RST_B),
      .wr_en   (REG_WR),
      .addr    (REG_ADDR),
      .wdata   (REG_WDATA),
      .pin_in  (PF_IN),
      .data_q  (pf_data),
      .dir_q   (pf_dir),
      .per_q   (pf_per),
      .pur_q   (pf_pur),
      .pin_q   (),
      .hit     (pf_hit),
      .rd_val  (pf_rd)
   );

   // a full compare keeps the port blocks' aliases off these two bits
   assign clko_hit   = is_reg(REG_ADDR, `GPM_CLOCK_OUT_SELECT_ADDR);
   assign busctl_hit = is_reg(REG_ADDR, `GPM_BUSCTL_ADDR);
   assign clko_wr    = REG_WR & clko_hit;
   assign busctl_wr  = REG_WR & busctl_hit;

   // next values of the control bits; a write elsewhere holds them
   always @* begin
      clko_sel_d = clko_sel_q;
      drv_keep_d = drv_keep_q;
      if (clko_wr) begin
         clko_sel_d = REG_WDATA[`GPM_CLKO_SEL_BIT];
      end
      if (busctl_wr) begin
         drv_keep_d = REG_WDATA[`GPM_DRV_KEEP_BIT];
      end
   end

   // clock out select and bus drive keep registers
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         clko_sel_q <= `GPM_CLOCK_OUT_SELECT_RST;
         drv_keep_q <= `GPM_BUSCTL_RST;
      end else begin
         clko_sel_q <= clko_sel_d;
         drv_keep_q <= drv_keep_d;
      end
   end

   assign BUS_DRIVE_KEEP = drv_keep_q;

   // with keep set the address pins, and the data pins while EMI_DATA_OE,
   // hold their drive between cycles, otherwise they float whenever no
   // bus cycle runs; keep trades a quiet bus between cycles for address
   // pins that never release to others
   assign addr_drive = EMI_BUS_ACTIVE | drv_keep_q;
   assign data_drive = EMI_DATA_OE & (EMI_BUS_ACTIVE | drv_keep_q);

   // pin 4 shows the clock only when peripheral enabled and selected;
   // the clock passes through combinationally so it is not resampled
   assign clk_on_pin = pb_per[`GPM_PB_CLK_PIN] & clko_sel_q;

   assign pb_alt_out = clk_on_pin ?
                       {PRESCALER_CLK, EMI_ADDR_HI[3:0]} :
                       EMI_ADDR_HI;
   assign pb_alt_oe  = clk_on_pin ?
                       {1'b1, {(`GPM_PB_W-1){addr_drive}}} :
                       {`GPM_PB_W{addr_drive}};

   // one enable per bus group; a group floats together between cycles
   assign pa_alt_oe = {`GPM_PA_W{addr_drive}};
   assign pf_alt_oe = {`GPM_PF_W{data_drive}};

   // port A pads: alternate is A8..A13; not bonded, so left to software
   gpm_pad_mux #(
      .W        (`GPM_PA_W)
   ) u_pad_a (
      .rst_b    (RST_B),
      .per_en   (pa_per),
      .gpio_out (pa_data),
      .gpio_dir (pa_dir),
      .alt_out  (EMI_ADDR_MID),
      .alt_oe   (pa_alt_oe),
      .pad_out  (PA_OUT),
      .pad_oe   (PA_OE)
   );

   // port B pads: A16..A20, pin 4 optionally the prescaler clock
   gpm_pad_mux #(
      .W        (`GPM_PB_W)
   ) u_pad_b (
      .rst_b    (RST_B),
      .per_en   (pb_per),
      .gpio_out (pb_data),
      .gpio_dir (pb_dir),
      .alt_out  (pb_alt_out),
      .alt_oe   (pb_alt_oe),
      .pad_out  (PB_OUT),
      .pad_oe   (PB_OE)
   );

   // port F pads: D7..D10, driven only on a bus write
   gpm_pad_mux #(
      .W        (`GPM_PF_W)
   ) u_pad_f (
      .rst_b    (RST_B),
      .per_en   (pf_per),
      .gpio_out (pf_data),
      .gpio_dir (pf_dir),
      .alt_out  (EMI_DOUT),
      .alt_oe   (pf_alt_oe),
      .pad_out  (PF_OUT),
      .pad_oe   (PF_OE)
   );

   // pull-ups follow the registers in either function; a driving pin
   // keeps its pull-up, which costs a little current when driven low
   assign PA_PU = pa_pur;
   assign PB_PU = pb_pur;
   assign PF_PU = pf_pur;

   // pins still in GPIO function are masked, so a floating or
   // GPIO-driven level never reaches the bus controller as data
   assign emi_din_d = PF_IN & pf_per;

   // bus read data from the data pins, one cycle of latency
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         emi_din_q <= 4'h0;
      end else begin
         emi_din_q <= emi_din_d;
      end
   end

   assign EMI_DIN = emi_din_q;

   // read decode; unmapped addresses read as zero
   always @* begin
      rdata_d = 16'h0000;
      if (pa_hit) begin
         rdata_d = pa_rd;
      end else if (pb_hit) begin
         rdata_d = pb_rd;
      end else if (pf_hit) begin
         rdata_d = pf_rd;
      end else if (clko_hit) begin
         rdata_d = {15'h0000, clko_sel_q};
      end else if (busctl_hit) begin
         rdata_d = {15'h0000, drv_keep_q};
      end else begin
         rdata_d = 16'h0000;
      end
   end

   // read data stands only in the cycle after the strobe;
   // zero outside that slot lets read paths be ORed further up
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_q <= 16'h0000;
      end else if (REG_RD) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign REG_RDATA = rdata_q;

endmodule // gpm_pin_mux
